// ===== design/eeprom_link_slave.sv
`timescale 1ns/1ps
// Contract
// - Byte array of 1024/512/256/128 locations
// - Respond only to type identifier 1010
// - Slave only; timing from serial clock
// - Start, then select byte with acknowledge slot
// - Acknowledge in ninth bit after receiving
// - Chip-select pins give select code LSBs
// - Absent chip-select pins compare as zero
// - Write-protect high blocks all array writes
// - Unconnected write-protect reads as low
// - Write-protect: ack select/address, nack data
// - Ignore bus until power-on reset releases
// - Reset reassertion stops responses immediately
// - Stop enters standby unless write running
// - Start is SDA fall while SCL high
// - Watch for Start except during write
// - Stop is SDA rise while SCL high
// - Nack then Stop returns to standby
// - Stop closing write starts programming cycle
// - Transmitter releases; receiver pulls ninth bit
// - Data line is open drain only
// - Sample data on rising serial clock edge
// - Select LSB: 1 read, 0 write
// - Mismatch: no ack, release, standby
// - Programming cycle: output off, ignore bus
module eeprom_link_slave #(
  parameter int         MEM_DEPTH     = eeprom_link_pkg::MEM_DEPTH_DEF,
  parameter int         PAGE_BYTES    = eeprom_link_pkg::PAGE_BYTES_DEF,
  parameter logic [2:0] CS_PRESENT    = eeprom_link_pkg::CS_ALL,
  parameter int         WRITE_TIME_NS = eeprom_link_pkg::WRITE_TIME_NS,
  parameter int         TW_CYCLES     =
    (WRITE_TIME_NS + eeprom_link_pkg::CORE_CLK_NS - 1) /
    eeprom_link_pkg::CORE_CLK_NS
) (
  input  wire logic core_clk,
  input  wire logic sample_clk,
  input  wire logic nrst,
  input  wire logic scl,
  input  wire logic sda_in,
  input  wire logic chip_select_pin_0,
  input  wire logic chip_select_pin_1,
  input  wire logic chip_select_pin_2,
  input  wire logic write_protect_input,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      write_busy
);

  localparam int ADDR_W  = $clog2(MEM_DEPTH);
  localparam int HI_BITS = (ADDR_W > eeprom_link_pkg::ADDR_BYTE_W) ?
                           ADDR_W - eeprom_link_pkg::ADDR_BYTE_W : 0;
  localparam int PG_W    = $clog2(PAGE_BYTES);
  localparam int CNT_W   = $clog2(TW_CYCLES + 1);

  function automatic logic select_match(input logic [7:0] sel,
                                        input logic [2:0] cs);
    logic ok;
    ok = (sel[7:eeprom_link_pkg::TYPE_LSB] == eeprom_link_pkg::TYPE_ID);
    for (int k = 0; k < eeprom_link_pkg::CS_BITS; k++) begin
      // Pins reused as address bits on larger arrays are not compared
      if (k >= HI_BITS && sel[eeprom_link_pkg::CS_LSB + k] != cs[k]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : select_match

  function automatic logic [ADDR_W-1:0] page_inc(
    input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    r = a;
    r[PG_W-1:0] = a[PG_W-1:0] + 1'b1;
    return r;
  endfunction : page_inc

  // ---------------- Link side, on the oversampling clock ----------------

  eeprom_link_pkg::line_pair_t  line_meta;
  eeprom_link_pkg::line_pair_t  line_sync;
  eeprom_link_pkg::line_pair_t  line_prev;
  eeprom_link_pkg::strap_t      strap_meta;
  eeprom_link_pkg::strap_t      strap_sync;

  always_ff @(posedge sample_clk or negedge nrst) begin
    if (!nrst) begin
      line_meta  <= '{scl: 1'b1, sda: 1'b1};
      line_sync  <= '{scl: 1'b1, sda: 1'b1};
      line_prev  <= '{scl: 1'b1, sda: 1'b1};
      strap_meta <= '0;
      strap_sync <= '0;
    end else begin
      line_meta  <= '{scl: scl, sda: sda_in};
      line_sync  <= line_meta;
      line_prev  <= line_sync;
      strap_meta <= '{wp: write_protect_input,
                      cs: {chip_select_pin_2, chip_select_pin_1,
                           chip_select_pin_0}};
      strap_sync <= strap_meta;
    end
  end

  eeprom_link_pkg::link_state_t state;
  eeprom_link_pkg::link_state_t next_state;
  logic [3:0]              cnt;
  logic [3:0]              next_cnt;
  logic [7:0]              shreg;
  logic [7:0]              next_shreg;
  logic [7:0]              sel_byte;
  logic [7:0]              next_sel_byte;
  logic [ADDR_W-1:0]       addr;
  logic [ADDR_W-1:0]       next_addr;
  logic                    next_oe;
  logic                    mack;
  logic                    next_mack;
  logic                    wr_pending;
  logic                    next_wr_pending;
  logic                    wip;
  logic                    next_wip;
  logic                    req_tog;
  logic                    done_meta;
  logic                    done_sync;
  logic                    done_seen;
  logic                    done_tog;
  logic [7:0]              mem [MEM_DEPTH];
  logic [7:0]              page_data [PAGE_BYTES];
  logic [PAGE_BYTES-1:0]   page_valid;

  wire scl_rise   = line_sync.scl & ~line_prev.scl;
  wire scl_fall   = ~line_sync.scl & line_prev.scl;
  wire start_cond = line_sync.scl & line_prev.scl &
                    line_prev.sda & ~line_sync.sda;
  wire stop_cond  = line_sync.scl & line_prev.scl &
                    ~line_prev.sda & line_sync.sda;
  // Pad pull-downs make a floating pin arrive here as zero
  wire       wp_high = strap_sync.wp;
  wire [2:0] cs_eff  = strap_sync.cs & CS_PRESENT;
  wire sel_ok     = select_match(shreg, cs_eff);
  wire ack_now    = scl_fall & (cnt == eeprom_link_pkg::CNT_ACK_DRV);
  wire slot_end   = scl_fall & (cnt == eeprom_link_pkg::CNT_ACK_SLOT);
  wire bit_in     = scl_rise & (cnt < eeprom_link_pkg::CNT_ACK_DRV);
  wire bus_gate   = ~wip & ~start_cond & ~stop_cond;
  wire in_sel     = (state == eeprom_link_pkg::st_sel);
  wire in_addr    = (state == eeprom_link_pkg::st_addr);
  wire in_wdata   = (state == eeprom_link_pkg::st_wdata);
  wire in_rdata   = (state == eeprom_link_pkg::st_rdata);
  wire in_mack    = (state == eeprom_link_pkg::st_mack);
  wire receiving  = in_sel | in_addr | in_wdata;
  wire rw_read    = (sel_byte[eeprom_link_pkg::RW_BIT] ==
                     eeprom_link_pkg::RW_READ);
  // Only a Stop in the slot right after a data acknowledge programs;
  // its clock rise has already been counted as the next frame's first bit
  wire write_trigger = stop_cond & ~wip & in_wdata &
                       (cnt == eeprom_link_pkg::CNT_STOP_BIT) & wr_pending;
  wire byte_store = bus_gate & in_wdata & ack_now & ~wp_high;
  wire next_read  = scl_fall & in_mack &
                    (cnt == eeprom_link_pkg::CNT_MACK_RX) & mack;
  wire read_load  = bus_gate & ((in_sel & slot_end & rw_read) | next_read);
  wire done_evt   = done_sync ^ done_seen;
  wire [7:0] rd_byte = mem[addr];
  wire [10:0] addr_full = {sel_byte[3:1], shreg};
  wire [2:0]  out_idx   = 3'(eeprom_link_pkg::BYTE_MSB - cnt[2:0]);

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_shreg      = shreg;
    next_sel_byte   = sel_byte;
    next_addr       = addr;
    next_oe         = sda_oe;
    next_mack       = mack;
    next_wr_pending = wr_pending;
    next_wip        = wip;
    if (wip) begin
      // Disconnected from the bus until the write cycle reports done
      next_state = eeprom_link_pkg::st_idle;
      next_cnt   = eeprom_link_pkg::CNT_ZERO;
      next_oe    = 1'b0;
      if (done_evt) begin
        next_wip = 1'b0;
      end
    end else if (start_cond) begin
      next_state      = eeprom_link_pkg::st_sel;
      next_cnt        = eeprom_link_pkg::CNT_ZERO;
      next_oe         = 1'b0;
      next_wr_pending = 1'b0;
    end else if (stop_cond) begin
      next_state = eeprom_link_pkg::st_idle;
      next_cnt   = eeprom_link_pkg::CNT_ZERO;
      next_oe    = 1'b0;
      next_wip   = write_trigger;
    end else begin
      case (state)
        eeprom_link_pkg::st_sel,
        eeprom_link_pkg::st_addr,
        eeprom_link_pkg::st_wdata: begin
          if (bit_in) begin
            next_shreg = {shreg[6:0], line_sync.sda};
            next_cnt   = cnt + 4'h1;
          end else if (ack_now) begin
            next_cnt = eeprom_link_pkg::CNT_ACK_SLOT;
            if (in_sel) begin
              next_sel_byte = shreg;
              if (sel_ok) begin
                next_oe = 1'b1;
              end else begin
                next_state = eeprom_link_pkg::st_idle;
                next_cnt   = eeprom_link_pkg::CNT_ZERO;
              end
            end else if (in_addr) begin
              next_oe   = 1'b1;
              next_addr = ADDR_W'(addr_full);
            end else if (!wp_high) begin
              next_oe         = 1'b1;
              next_wr_pending = 1'b1;
              next_addr       = page_inc(addr);
            end
          end else if (slot_end) begin
            next_oe  = 1'b0;
            next_cnt = eeprom_link_pkg::CNT_ZERO;
            if (in_sel && rw_read) begin
              next_state = eeprom_link_pkg::st_rdata;
              next_shreg = rd_byte;
              next_addr  = addr + 1'b1;
              next_oe    = ~rd_byte[eeprom_link_pkg::BYTE_MSB];
            end else if (in_sel) begin
              next_state = eeprom_link_pkg::st_addr;
            end else if (in_addr) begin
              next_state = eeprom_link_pkg::st_wdata;
            end
          end
        end
        eeprom_link_pkg::st_rdata: begin
          if (bit_in) begin
            next_cnt = cnt + 4'h1;
          end else if (ack_now) begin
            next_oe    = 1'b0;
            next_state = eeprom_link_pkg::st_mack;
            next_cnt   = eeprom_link_pkg::CNT_ZERO;
          end else if (scl_fall && cnt != eeprom_link_pkg::CNT_ZERO) begin
            next_oe = ~shreg[out_idx];
          end
        end
        eeprom_link_pkg::st_mack: begin
          if (scl_rise) begin
            next_mack = ~line_sync.sda;
            next_cnt  = eeprom_link_pkg::CNT_MACK_RX;
          end else if (next_read) begin
            next_state = eeprom_link_pkg::st_rdata;
            next_cnt   = eeprom_link_pkg::CNT_ZERO;
            next_shreg = rd_byte;
            next_addr  = addr + 1'b1;
            next_oe    = ~rd_byte[eeprom_link_pkg::BYTE_MSB];
          end else if (scl_fall && cnt == eeprom_link_pkg::CNT_MACK_RX) begin
            // No acknowledge: wait for the Stop that ends the read
            next_state = eeprom_link_pkg::st_hold;
          end
        end
        eeprom_link_pkg::st_idle,
        eeprom_link_pkg::st_hold: begin
          next_oe = 1'b0;
        end
        default: begin
          next_state = eeprom_link_pkg::st_idle;
          next_oe    = 1'b0;
        end
      endcase
    end
  end

  // Reset holds everything quiet, both at power-up and on supply decay
  always_ff @(posedge sample_clk or negedge nrst) begin
    if (!nrst) begin
      state      <= eeprom_link_pkg::st_idle;
      cnt        <= eeprom_link_pkg::CNT_ZERO;
      shreg      <= '0;
      sel_byte   <= '0;
      addr       <= '0;
      sda_oe     <= 1'b0;
      mack       <= 1'b0;
      wr_pending <= 1'b0;
      wip        <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      shreg      <= next_shreg;
      sel_byte   <= next_sel_byte;
      addr       <= next_addr;
      sda_oe     <= next_oe;
      mack       <= next_mack;
      wr_pending <= next_wr_pending;
      wip        <= next_wip;
    end
  end

  // The pin is only ever pulled low; the output level never changes
  always_ff @(posedge sample_clk or negedge nrst) begin
    if (!nrst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge sample_clk or negedge nrst) begin
    if (!nrst) begin
      page_valid <= '0;
      req_tog    <= 1'b0;
      done_meta  <= 1'b0;
      done_sync  <= 1'b0;
      done_seen  <= 1'b0;
    end else begin
      done_meta <= done_tog;
      done_sync <= done_meta;
      done_seen <= done_sync;
      if (write_trigger) begin
        req_tog <= ~req_tog;
      end
      if (done_evt || (start_cond && !wip)) begin
        page_valid <= '0;
      end else if (byte_store) begin
        page_valid[addr[PG_W-1:0]] <= 1'b1;
      end
    end
  end

  // Page latches and array carry no reset: contents survive a reset pulse
  always_ff @(posedge sample_clk) begin
    if (byte_store) begin
      page_data[addr[PG_W-1:0]] <= shreg;
    end
    if (done_evt) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_valid[i]) begin
          mem[{addr[ADDR_W-1:PG_W], PG_W'(i)}] <= page_data[i];
        end
      end
    end
  end

  // ---------------- Write-cycle timer, on the core clock ----------------

  logic             req_meta;
  logic             req_sync;
  logic             req_seen;
  logic [CNT_W-1:0] tw_cnt;

  wire req_evt = req_sync ^ req_seen;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      req_meta   <= 1'b0;
      req_sync   <= 1'b0;
      req_seen   <= 1'b0;
      done_tog   <= 1'b0;
      write_busy <= 1'b0;
      tw_cnt     <= '0;
    end else begin
      req_meta <= req_tog;
      req_sync <= req_meta;
      req_seen <= req_sync;
      if (req_evt) begin
        write_busy <= 1'b1;
        tw_cnt     <= CNT_W'(TW_CYCLES - 1);
      end else if (write_busy && tw_cnt == '0) begin
        write_busy <= 1'b0;
        done_tog   <= ~done_tog;
      end else if (write_busy) begin
        tw_cnt <= tw_cnt - 1'b1;
      end
    end
  end

  // ---------------- Checks ----------------

  sequence s_ack_drive;
    bus_gate & ack_now;
  endsequence

  sequence s_slot_close;
    bus_gate & slot_end;
  endsequence

  property p_open_drain;
    @(posedge sample_clk) disable iff (!nrst)
      sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data line driven high");

  property p_sel_ack;
    @(posedge sample_clk) disable iff (!nrst)
      (s_ack_drive and in_sel & sel_ok) |=> sda_oe ##1 sda_oe;
  endproperty
  a_sel_ack: assert property (p_sel_ack)
    else $error("matching select byte not acknowledged");

  property p_no_match;
    @(posedge sample_clk) disable iff (!nrst)
      (s_ack_drive and in_sel & ~sel_ok) |=>
        !sda_oe && state == eeprom_link_pkg::st_idle;
  endproperty
  a_no_match: assert property (p_no_match)
    else $error("mismatched select byte answered");

  property p_wp_nack;
    @(posedge sample_clk) disable iff (!nrst)
      (s_ack_drive and in_wdata & wp_high) |=>
        !sda_oe && $stable(page_valid);
  endproperty
  a_wp_nack: assert property (p_wp_nack)
    else $error("protected data byte acknowledged");

  property p_trigger;
    @(posedge sample_clk) disable iff (!nrst)
      write_trigger |=> wip && $changed(req_tog);
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("Stop after data did not start write cycle");

  property p_wip_quiet;
    @(posedge sample_clk) disable iff (!nrst)
      wip |=> !sda_oe && state == eeprom_link_pkg::st_idle;
  endproperty
  a_wip_quiet: assert property (p_wip_quiet)
    else $error("bus answered during write cycle");

  property p_start;
    @(posedge sample_clk) disable iff (!nrst)
      (start_cond & ~wip) |=>
        state == eeprom_link_pkg::st_sel &&
        cnt == eeprom_link_pkg::CNT_ZERO;
  endproperty
  a_start: assert property (p_start)
    else $error("Start not recognised");

  property p_stop;
    @(posedge sample_clk) disable iff (!nrst)
      (stop_cond & ~wip & ~write_trigger) |=>
        state == eeprom_link_pkg::st_idle && !wip;
  endproperty
  a_stop: assert property (p_stop)
    else $error("Stop did not return to standby");

  property p_release;
    @(posedge sample_clk) disable iff (!nrst)
      (s_slot_close and in_addr) |=> !sda_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("acknowledge not released after slot");

  property p_read_load;
    @(posedge sample_clk) disable iff (!nrst)
      read_load |=> in_rdata &&
        sda_oe == ~shreg[eeprom_link_pkg::BYTE_MSB];
  endproperty
  a_read_load: assert property (p_read_load)
    else $error("read byte not put on the line");

  property p_sample;
    @(posedge sample_clk) disable iff (!nrst)
      (bus_gate & receiving & bit_in) |=>
        shreg[0] == $past(line_sync.sda);
  endproperty
  a_sample: assert property (p_sample)
    else $error("received bit not taken on rising clock");

  property p_timer;
    @(posedge core_clk) disable iff (!nrst)
      req_evt |=> write_busy [*8];
  endproperty
  a_timer: assert property (p_timer)
    else $error("write cycle ended too early");

endmodule : eeprom_link_slave

// ===== design/eeprom_link_pkg.sv
package eeprom_link_pkg;

  // Select byte layout
  localparam logic [3:0] TYPE_ID      = 4'hA;
  localparam int         TYPE_LSB     = 4;
  localparam int         CS_LSB       = 1;
  localparam int         CS_BITS      = 3;
  localparam int         RW_BIT       = 0;
  localparam logic       RW_READ      = 1'h1;
  localparam int         BYTE_BITS    = 8;
  localparam int         BYTE_MSB     = 7;

  // Bit counter values inside one byte frame
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_ACK_DRV  = 4'h8;
  localparam logic [3:0] CNT_ACK_SLOT = 4'h9;
  localparam logic [3:0] CNT_MACK_RX  = 4'h1;
  // A Stop after a data acknowledge comes one clock into the next frame
  localparam logic [3:0] CNT_STOP_BIT = 4'h1;

  // Chip-select pins that are bonded out; absent ones read as zero
  localparam logic [2:0] CS_ALL       = 3'h7;

  // Memory organisation defaults
  localparam int         MEM_DEPTH_DEF  = 1024;
  localparam int         PAGE_BYTES_DEF = 8;
  localparam int         ADDR_BYTE_W    = 8;

  // Timing: core clock period and self-timed write duration
  localparam int         CORE_CLK_NS    = 40;
  localparam int         WRITE_TIME_NS  = 5000000;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_pair_t;

  typedef struct packed {
    logic       wp;
    logic [2:0] cs;
  } strap_t;

  typedef enum logic [6:0] {
    st_idle  = 7'h01,
    st_sel   = 7'h02,
    st_addr  = 7'h04,
    st_wdata = 7'h08,
    st_rdata = 7'h10,
    st_mack  = 7'h20,
    st_hold  = 7'h40
  } link_state_t;

endpackage : eeprom_link_pkg

// ===== tb/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic       core_clk,
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_low,
  output logic            got_tgl,
  output logic [8:0]      got
);
  initial begin
    scl     = 1'h1;
    sda_low = 1'h0;
    got_tgl = 1'h0;
    got     = 9'h000;
  end

  // Only this side moves the clock, which idles high between frames
  task automatic step(input logic c, input logic d);
    @(posedge core_clk);
    scl     <= c;
    sda_low <= d;
  endtask : step

  // Start is cond(0, 1) and Stop is cond(1, 0)
  task automatic cond(input logic a, input logic b);
    step(1'h0, sda_low);
    step(1'h0, a);
    step(1'h1, a);
    step(1'h1, a);
    step(1'h1, b);
    step(1'h1, b);
  endtask : cond

  // A 1 in tx releases the line, so a read byte is sent as all ones
  task automatic bit9(input logic [8:0] tx);
    logic [8:0] rx;
    for (int i = 8; i >= 0; i--) begin
      step(1'h0, sda_low);
      step(1'h0, ~tx[i]);
      step(1'h1, ~tx[i]);
      step(1'h1, ~tx[i]);
      rx[i] = sda;
    end
    got     <= rx;
    got_tgl <= ~got_tgl;
  endtask : bit9
endmodule : i2c_master_model

// ===== tb/tb_serial_eeprom_i2c_slave_front_end.sv
`timescale 1ns/1ps
module tb_serial_eeprom_i2c_slave_front_end;
  logic                    core_clk   = 1'h0;
  logic                    sample_clk = 1'h0;
  logic                    nrst       = 1'h0;
  eeprom_link_pkg::strap_t strap      = 4'h0;
  logic                    seen       = 1'h0;
  logic                    scl;
  logic                    sda_low;
  logic                    got_tgl;
  logic [8:0]              got;
  logic                    sda_out;
  logic                    sda_oe;
  logic                    write_busy;
  logic [8:0]              expq[$];
  logic [7:0]              a;
  logic [7:0]              d0;
  logic [7:0]              d1;
  logic [7:0]              sw;
  int                      errors     = 0;
  int                      tests_run  = 0;
  // Pull-up wins unless someone pulls low
  wire logic sda = (sda_low | (sda_oe & ~sda_out)) ? 1'h0 : 1'h1;

  always #20 core_clk = ~core_clk;
  initial begin
    #1.3;
    forever #3 sample_clk = ~sample_clk;
  end

  // Short write time keeps the run small
  eeprom_link_slave #(
    .MEM_DEPTH (256),
    .TW_CYCLES (100)
  ) i_eeprom_link_slave (
    .core_clk            (core_clk),
    .sample_clk          (sample_clk),
    .nrst                (nrst),
    .scl                 (scl),
    .sda_in              (sda),
    .chip_select_pin_0   (strap.cs[0]),
    .chip_select_pin_1   (strap.cs[1]),
    .chip_select_pin_2   (strap.cs[2]),
    .write_protect_input (strap.wp),
    .sda_out             (sda_out),
    .sda_oe              (sda_oe),
    .write_busy          (write_busy)
  );

  i2c_master_model i_i2c_master_model (
    .core_clk (core_clk),
    .sda      (sda),
    .scl      (scl),
    .sda_low  (sda_low),
    .got_tgl  (got_tgl),
    .got      (got)
  );

  task automatic check(input logic [8:0] g, input logic [8:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Each slot result from the master is matched to the oldest note
  always @(posedge core_clk) begin
    if (got_tgl !== seen) begin
      seen <= got_tgl;
      check(got, expq.size() > 0 ? expq.pop_front() : ~got);
    end
  end

  task automatic frame(input logic s);
    i_i2c_master_model.cond(~s, s);
  endtask : frame

  task automatic wr(input logic [7:0] b, input logic nack);
    expq.push_back({b, nack});
    i_i2c_master_model.bit9({b, 1'h1});
  endtask : wr

  task automatic rd(input logic [7:0] e, input logic nack);
    expq.push_back({e, nack});
    i_i2c_master_model.bit9({8'hFF, nack});
  endtask : rd

  task automatic wait_busy(input logic lvl);
    for (int n = 0; n < 400 && write_busy !== lvl; n++) begin
      @(posedge core_clk);
    end
    check({8'h00, write_busy}, {8'h00, lvl});
    if (write_busy !== lvl) begin
      wrap_up();
    end
  endtask : wait_busy

  // Dummy write sets the address, then a repeated start turns to read
  task automatic seek;
    frame(1'h1);
    wr(sw, 1'h0);
    wr(a, 1'h0);
    frame(1'h1);
    wr(sw | 8'h01, 1'h0);
  endtask : seek

  initial begin
    repeat (30000) @(posedge core_clk);
    errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h089187D7));
    a  = 8'($urandom) & 8'hF8;
    d0 = 8'($urandom) & 8'h7F;
    d1 = 8'($urandom);
    @(posedge core_clk);
    strap.cs <= 3'($urandom);
    repeat (10) @(posedge core_clk);
    nrst <= 1'h1;
    repeat (4) @(posedge core_clk);
    sw = {eeprom_link_pkg::TYPE_ID, strap.cs, 1'h0};

    frame(1'h1);
    wr(sw, 1'h0);
    wr(a, 1'h0);
    wr(d0, 1'h0);
    wr(d1, 1'h0);
    frame(1'h0);
    wait_busy(1'h1);
    frame(1'h1);
    wr(sw, 1'h1);
    frame(1'h0);
    wait_busy(1'h0);
    $display("test page write done");

    seek();
    rd(d0, 1'h0);
    rd(d1, 1'h1);
    frame(1'h0);
    $display("test sequential read done");

    // Flip each strap bit, then one type bit
    for (int i = 0; i < 4; i++) begin
      frame(1'h1);
      wr(sw ^ 8'(8'h02 << i), 1'h1);
      frame(1'h0);
    end
    $display("test select mismatch done");

    strap.wp <= 1'h1;
    frame(1'h1);
    wr(sw, 1'h0);
    wr(a, 1'h0);
    wr(~d0, 1'h1);
    frame(1'h0);
    repeat (10) @(posedge core_clk);
    check({8'h00, write_busy}, 9'h000);
    strap.wp <= 1'h0;
    seek();
    rd(d0, 1'h1);
    frame(1'h0);
    $display("test write protect done");

    // Top bit of d0 is zero, so the device is pulling when reset hits
    seek();
    i_i2c_master_model.step(1'h0, 1'h0);
    repeat (3) @(posedge core_clk);
    check({8'h00, sda_oe}, 9'h001);
    nrst <= 1'h0;
    @(negedge core_clk);
    check({8'h00, sda_oe}, 9'h000);
    repeat (10) @(posedge core_clk);
    nrst <= 1'h1;
    frame(1'h0);
    frame(1'h1);
    wr(sw, 1'h0);
    frame(1'h0);
    repeat (5) @(posedge core_clk);
    $display("test reset in transfer done");
    wrap_up();
  end
endmodule : tb_serial_eeprom_i2c_slave_front_end
